// >>> rtl/fcs_flash_cmd.sv
// flash command launch, buffering and status flags behind an apb slave
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_flash_cmd
  import fcs_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  input wire logic stop_req,
  input wire logic array_blank,
  // array operation request and security state
  output logic op_start,
  output logic [7:0] op_cmd,
  output logic [15:0] op_addr,
  output logic [7:0] op_data,
  output logic [1:0] security_state
);
  fcs_state_t st_ff;
  fcs_state_t nxt_st;
  logic busy;
  logic done;
  logic access;
  logic wr;
  logic rd_phase;
  logic mapped;
  logic launch;
  logic accept;
  logic legal;
  logic is_pe;
  logic prot_hit;
  logic seq_err;
  logic stop_err;
  logic [7:0] status_rd;

  fcs_op_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(st_ff.op_start),
    .abort(stop_err),
    .kind(st_ff.op_cmd),
    .busy(busy),
    .done(done)
  );

  // apb: first access cycle raises pready, the edge after it completes the transfer
  assign access = psel && penable && st_ff.pready;
  assign rd_phase = psel && penable && !st_ff.pready;
  assign wr = access && pwrite;
  assign mapped = (paddr == `FCS_OFF_STATUS) || (paddr == `FCS_OFF_CMD) ||
    (paddr == `FCS_OFF_DATA) || (paddr == `FCS_OFF_CFG) || (paddr == `FCS_OFF_SEC);

  // decode of the five codes; everything else is illegal
  always_comb
  begin
    case (st_ff.cmd)
      `FCS_CMD_BLANK, `FCS_CMD_BYTE, `FCS_CMD_BURST: legal = 1'b1;
      `FCS_CMD_PAGE, `FCS_CMD_MASS: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  assign is_pe = legal && (st_ff.cmd != `FCS_CMD_BLANK);
  assign prot_hit = is_pe && st_ff.cfg_prot &&
    ((st_ff.cmd == `FCS_CMD_MASS) || (st_ff.addr >= st_ff.prot_base));
  assign launch = wr && (paddr == `FCS_OFF_STATUS) && pwdata[`FCS_BIT_CBEF];
  // buffer must be empty, and a running command only admits a queued burst
  assign seq_err = (st_ff.seq != FCS_SEQ_CMD) || !legal || !st_ff.cbef ||
    (is_pe && !st_ff.cfg_div) || ((busy || st_ff.op_start) &&
    (st_ff.cmd != `FCS_CMD_BURST));
  assign accept = launch && !seq_err && !prot_hit;
  assign stop_err = st_ff.stop_s2 && (busy || st_ff.buf_valid || st_ff.op_start);

  assign status_rd = {st_ff.cbef, st_ff.ccf, st_ff.pviol, st_ff.accerr,
    1'b0, st_ff.blank, 2'b00};

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.stop_s1 = stop_req;
    nxt_st.stop_s2 = st_ff.stop_s1;
    nxt_st.blank_s1 = array_blank;
    nxt_st.blank_s2 = st_ff.blank_s1;
    nxt_st.op_start = 1'b0;
    nxt_st.pready = rd_phase;
    if (rd_phase)
    begin
      nxt_st.pslverr = !mapped;
      case (paddr)
        `FCS_OFF_STATUS: nxt_st.prdata = {24'h000000, status_rd};
        `FCS_OFF_CMD: nxt_st.prdata = {24'h000000, st_ff.cmd};
        `FCS_OFF_DATA: nxt_st.prdata = {8'h00, st_ff.addr, st_ff.data};
        `FCS_OFF_CFG: nxt_st.prdata = {st_ff.prot_base, 9'h000, st_ff.cfg_prot,
          st_ff.cfg_key, 4'h0, st_ff.cfg_div};
        `FCS_OFF_SEC: nxt_st.prdata = {30'h00000000, st_ff.sec};
        default: nxt_st.prdata = 32'h00000000;
      endcase
    end
    // write-1 clears first, so a hardware set in the same cycle wins
    if (wr && (paddr == `FCS_OFF_STATUS))
    begin
      if (pwdata[`FCS_BIT_PVIOL])
      begin
        nxt_st.pviol = 1'b0;
      end
      if (pwdata[`FCS_BIT_ACCERR])
      begin
        nxt_st.accerr = 1'b0;
      end
    end
    if (wr && (paddr == `FCS_OFF_CFG))
    begin
      nxt_st.cfg_div = pwdata[`FCS_CFG_DIVSET];
      nxt_st.cfg_key = pwdata[`FCS_CFG_KEY_WRITE_SELECT];
      nxt_st.cfg_prot = pwdata[`FCS_CFG_PROTEN];
      nxt_st.prot_base = pwdata[31:16];
    end
    // array data write opens a sequence from idle, otherwise flags accerr, unless it is a key comparison write
    if (wr && (paddr == `FCS_OFF_DATA) && !(st_ff.cfg_key &&
      (pwdata[23:8] >= `FCS_KEY_LO) && (pwdata[23:8] <= `FCS_KEY_HI)))
    begin
      case (st_ff.seq)
        FCS_SEQ_IDLE:
        begin
          nxt_st.addr = pwdata[23:8];
          nxt_st.data = pwdata[7:0];
          nxt_st.seq = FCS_SEQ_DATA;
        end
        default:
        begin
          nxt_st.accerr = 1'b1;
          nxt_st.seq = FCS_SEQ_IDLE;
        end
      endcase
    end
    if (wr && (paddr == `FCS_OFF_CMD))
    begin
      nxt_st.cmd = pwdata[7:0];
      case (st_ff.seq)
        FCS_SEQ_DATA: nxt_st.seq = FCS_SEQ_CMD;
        default:
        begin
          nxt_st.accerr = 1'b1;
          nxt_st.seq = FCS_SEQ_IDLE;
        end
      endcase
    end
    if (launch)
    begin
      nxt_st.seq = FCS_SEQ_IDLE;
      if (seq_err)
      begin
        nxt_st.accerr = 1'b1;
      end
      else if (prot_hit)
      begin
        nxt_st.pviol = 1'b1;
      end
      else
      begin
        nxt_st.cbef = 1'b0;
        nxt_st.blank = 1'b0;
        nxt_st.buf_valid = 1'b1;
        nxt_st.buf_cmd = st_ff.cmd;
        nxt_st.buf_addr = st_ff.addr;
        nxt_st.buf_data = st_ff.data;
      end
    end
    // hand the buffered command to the array once it is free
    if (st_ff.buf_valid && !busy && !st_ff.op_start && !stop_err)
    begin
      nxt_st.buf_valid = 1'b0;
      nxt_st.cbef = 1'b1;
      nxt_st.op_start = 1'b1;
      nxt_st.op_cmd = st_ff.buf_cmd;
      nxt_st.op_addr = st_ff.buf_addr;
      nxt_st.op_data = st_ff.buf_data;
      nxt_st.run_cmd = st_ff.buf_cmd;
    end
    if (done && (st_ff.run_cmd == `FCS_CMD_BLANK))
    begin
      nxt_st.blank = st_ff.blank_s2;
      if (st_ff.blank_s2)
      begin
        nxt_st.sec = `FCS_SEC_UNSEC;
      end
    end
    // stop mode mid-command aborts everything pending
    if (stop_err)
    begin
      nxt_st.accerr = 1'b1;
      nxt_st.buf_valid = 1'b0;
      nxt_st.cbef = 1'b1;
      nxt_st.op_start = 1'b0;
    end
    // a command handed over last cycle has not raised the timer busy yet
    nxt_st.ccf = nxt_st.cbef && !nxt_st.buf_valid && !nxt_st.op_start &&
      (!st_ff.op_start || stop_err) && (!busy || stop_err || done);
    if (accept)
    begin
      nxt_st.ccf = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.seq <= FCS_SEQ_IDLE;
      st_ff.cbef <= 1'b1;
      st_ff.ccf <= 1'b1;
      st_ff.cmd <= `FCS_RST_CMD;
      st_ff.prot_base <= `FCS_RST_PROT_BASE;
      st_ff.sec <= `FCS_SEC_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign op_start = st_ff.op_start;
  assign op_cmd = st_ff.op_cmd;
  assign op_addr = st_ff.op_addr;
  assign op_data = st_ff.op_data;
  assign security_state = st_ff.sec;

  a_launch_cbef: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> !st_ff.cbef) else $error("buffer empty flag not cleared by launch");
  a_buf_burst: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.buf_valid && busy) |-> (st_ff.buf_cmd == `FCS_CMD_BURST))
    else $error("non-burst command queued behind a running one");
  a_ccf_launch: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> !st_ff.ccf ##1 !st_ff.ccf) else $error("complete flag stayed set");
  a_ccf_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.cbef && !st_ff.buf_valid && !busy && !st_ff.op_start && !accept) |=> st_ff.ccf)
    else $error("complete flag not set when idle");
  a_pviol_set: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && !seq_err && prot_hit) |=> (st_ff.pviol && !st_ff.buf_valid))
    else $error("protected command not flagged or not dropped");
  a_accerr_set: assert property (@(posedge pclk) disable iff (!presetn)
    (launch && !legal) |=> (st_ff.accerr && !st_ff.op_start && !st_ff.buf_valid))
    else $error("illegal code did not raise access error");
  a_accerr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.accerr && wr && (paddr == `FCS_OFF_STATUS) && !pwdata[`FCS_BIT_ACCERR])
    |=> st_ff.accerr) else $error("access error cleared by write of 0");
  a_blank_clr: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> !st_ff.blank) else $error("blank flag not cleared by launch");
  a_sec_unlock: assert property (@(posedge pclk) disable iff (!presetn)
    (done && (st_ff.run_cmd == `FCS_CMD_BLANK) && st_ff.blank_s2)
    |=> (st_ff.blank && (st_ff.sec == `FCS_SEC_UNSEC)))
    else $error("successful blank check did not unlock");
  a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(st_ff.pready) && ($past(paddr) == `FCS_OFF_STATUS))
    |-> (st_ff.prdata[3] == 1'b0 && st_ff.prdata[1:0] == 2'b00))
    else $error("reserved status bits read nonzero");
endmodule

// >>> rtl/fcs_op_timer.sv
// array operation timer paced by a divided clock enable
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_op_timer
  import fcs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] kind,
  // status
  output logic busy,
  output logic done
);
  fcs_tmr_t st_ff;
  fcs_tmr_t nxt_st;
  logic tick;

  assign tick = (st_ff.div == 8'h00);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.div = tick ? (`FCS_DIV_CYCLES - 8'h01) : (st_ff.div - 8'h01);
    if (abort)
    begin
      nxt_st.busy = 1'b0;
    end
    else if (start)
    begin
      nxt_st.busy = 1'b1;
      case (kind)
        `FCS_CMD_BLANK: nxt_st.cnt = `FCS_BLANK_TICKS;
        `FCS_CMD_PAGE, `FCS_CMD_MASS: nxt_st.cnt = `FCS_ERASE_TICKS;
        default: nxt_st.cnt = `FCS_PROG_TICKS;
      endcase
    end
    else if (st_ff.busy && tick)
    begin
      if (st_ff.cnt == 8'h01)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
      nxt_st.cnt = st_ff.cnt - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;
endmodule

// >>> rtl/fcs_params.svh
// offsets, field positions, codes, reset values and timing counts of the command logic
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_OFF_STATUS 12'h000
`define FCS_OFF_CMD 12'h004
`define FCS_OFF_DATA 12'h008
`define FCS_OFF_CFG 12'h00c
`define FCS_OFF_SEC 12'h010
`define FCS_BIT_CBEF 7
`define FCS_BIT_CCF 6
`define FCS_BIT_PVIOL 5
`define FCS_BIT_ACCERR 4
`define FCS_BIT_BLANK 2
`define FCS_CFG_DIVSET 0
`define FCS_CFG_KEY_WRITE_SELECT 5
`define FCS_CFG_PROTEN 6
`define FCS_CMD_BLANK 8'h05
`define FCS_CMD_BYTE 8'h20
`define FCS_CMD_BURST 8'h25
`define FCS_CMD_PAGE 8'h40
`define FCS_CMD_MASS 8'h41
`define FCS_KEY_LO 16'hffb0
`define FCS_KEY_HI 16'hffb7
`define FCS_SEC_UNSEC 2'h2
`define FCS_SEC_RESET 2'h0
`define FCS_RST_CMD 8'h00
`define FCS_RST_PROT_BASE 16'hfe00
`define FCS_DIV_CYCLES 8'h08
`define FCS_PROG_TICKS 8'h0a
`define FCS_ERASE_TICKS 8'h28
`define FCS_BLANK_TICKS 8'h14
`endif

// >>> rtl/fcs_pkg.sv
// types of the flash command and status logic
package fcs_pkg;
  typedef enum logic [2:0] {
    FCS_SEQ_IDLE = 3'h1,
    FCS_SEQ_DATA = 3'h2,
    FCS_SEQ_CMD = 3'h4
  } fcs_seq_t;

  typedef struct packed {
    logic [7:0] div;
    logic [7:0] cnt;
    logic busy;
    logic done;
  } fcs_tmr_t;

  typedef struct packed {
    fcs_seq_t seq;
    logic cbef;
    logic ccf;
    logic pviol;
    logic accerr;
    logic blank;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
    logic buf_valid;
    logic [7:0] buf_cmd;
    logic [15:0] buf_addr;
    logic [7:0] buf_data;
    logic [7:0] run_cmd;
    logic cfg_div;
    logic cfg_key;
    logic cfg_prot;
    logic [15:0] prot_base;
    logic [1:0] sec;
    logic op_start;
    logic [7:0] op_cmd;
    logic [15:0] op_addr;
    logic [7:0] op_data;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic stop_s1;
    logic stop_s2;
    logic blank_s1;
    logic blank_s2;
  } fcs_state_t;
endpackage

// >>> tb/fcs_flash_cmd_tb_top.sv
// self-checking bench of the flash command and status logic
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_flash_cmd_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_req = 1'b0;
  logic array_blank = 1'b0;
  logic op_start;
  logic [7:0] op_cmd;
  logic [15:0] op_addr;
  logic [7:0] op_data;
  logic [1:0] security_state;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int compares = 0;
  int ops = 0;
  int o;

  always #20 pclk = ~pclk;

  // counts commands handed to the array
  always @(posedge pclk)
    if (op_start === 1'b1)
      ops++;

  fcs_flash_cmd dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .stop_req(stop_req),
    .array_blank(array_blank),
    .op_start(op_start),
    .op_cmd(op_cmd),
    .op_addr(op_addr),
    .op_data(op_data),
    .security_state(security_state)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      err_count++;
  endtask

  task automatic stat(input logic [7:0] e);
    apb(1'b0, `FCS_OFF_STATUS, 32'h0);
    chk(rd, {24'h0, e});
  endtask

  task automatic wst(input logic [7:0] d);
    apb(1'b1, `FCS_OFF_STATUS, {24'h0, d});
  endtask

  task automatic cfg(input logic [31:0] d);
    apb(1'b1, `FCS_OFF_CFG, d);
  endtask

  // data, command, then launch
  task automatic go(input logic [15:0] a, input logic [7:0] c);
    apb(1'b1, `FCS_OFF_DATA, {8'h00, a, 8'h5a});
    apb(1'b1, `FCS_OFF_CMD, {24'h0, c});
    wst(8'h80);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `FCS_OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[6] !== 1'b1 && n < 200);
    chk(32'(rd[6]), 32'h1);
  endtask

  task automatic t_reset();
    stat(8'hc0);
    chk(32'(security_state), 32'h0);
    wst(8'h4d);
    stat(8'hc0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_errs();
    o = ops;
    go(16'h1000, `FCS_CMD_BYTE);
    stat(8'hd0);
    wst(8'h00);
    stat(8'hd0);
    wst(8'h10);
    stat(8'hc0);
    chk(ops - o, 0);
    cfg(32'hfe000001);
    apb(1'b1, `FCS_OFF_CMD, {24'h0, `FCS_CMD_BYTE});
    wst(8'h80);
    stat(8'hd0);
    wst(8'h10);
  endtask

  task automatic t_codes();
    logic [7:0] codes [6];
    codes = '{`FCS_CMD_BLANK, `FCS_CMD_BYTE, `FCS_CMD_BURST, `FCS_CMD_PAGE, `FCS_CMD_MASS, 8'h33};
    for (int i = 0; i < 6; i++)
    begin
      o = ops;
      go(16'h1000, codes[i]);
      if (i == 5)
      begin
        stat(8'hd0);
        wst(8'h10);
      end
      else
      begin
        stat(8'h80);
        wait_done();
        chk(ops - o, 1);
        chk(32'(op_cmd), 32'(codes[i]));
        chk(32'(op_addr), 32'h1000);
        chk(32'(op_data), 32'h5a);
      end
    end
  endtask

  task automatic t_blank();
    array_blank <= 1'b1;
    go(16'h0000, `FCS_CMD_BLANK);
    wait_done();
    stat(8'hc4);
    chk(32'(security_state), 32'h2);
    wst(8'h04);
    stat(8'hc4);
    array_blank <= 1'b0;
    go(16'h0000, `FCS_CMD_BLANK);
    stat(8'h80);
    wait_done();
    stat(8'hc0);
  endtask

  task automatic t_prot();
    cfg(32'hfe000041);
    o = ops;
    go(16'hff00, `FCS_CMD_BYTE);
    stat(8'he0);
    wst(8'h20);
    stat(8'hc0);
    go(16'h1000, `FCS_CMD_BYTE);
    wait_done();
    chk(ops - o, 1);
    cfg(32'hfe000001);
    go(16'hffb0, `FCS_CMD_BYTE);
    wait_done();
    chk(32'(op_addr), 32'hffb0);
    cfg(32'hfe000021);
    apb(1'b1, `FCS_OFF_DATA, {8'h00, 16'hffb3, 8'h11});
    apb(1'b1, `FCS_OFF_CMD, {24'h0, `FCS_CMD_BYTE});
    stat(8'hd0);
    wst(8'h10);
    cfg(32'hfe000001);
  endtask

  task automatic t_burst();
    o = ops;
    go(16'h2000, `FCS_CMD_BURST);
    go(16'h2001, `FCS_CMD_BURST);
    stat(8'h00);
    go(16'h2002, `FCS_CMD_BURST);
    stat(8'h10);
    wait_done();
    chk(ops - o, 2);
    chk(32'(op_addr), 32'h2001);
    wst(8'h10);
    go(16'h2000, `FCS_CMD_BURST);
    go(16'h2004, `FCS_CMD_BYTE);
    stat(8'h90);
    wait_done();
    wst(8'h10);
    stat(8'hc0);
  endtask

  task automatic t_stop();
    go(16'h1000, `FCS_CMD_PAGE);
    @(posedge pclk);
    stop_req <= 1'b1;
    repeat (4) @(posedge pclk);
    stop_req <= 1'b0;
    stat(8'hd0);
    wst(8'h10);
  endtask

  task automatic close_out();
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_errs();
    t_codes();
    t_blank();
    t_prot();
    t_burst();
    t_stop();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out();
  end
endmodule
